// [src/adcts_trigger_seq.sv]
// adc trigger sequencer: apb registers, start/trigger control, channel stepping
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module adcts_trigger_seq
  import adcts_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger and power
  input  wire logic        trigger_edge_input,
  input  wire logic        low_power_req,
  // analog front end
  input  wire logic        comp_in,
  output logic      [2:0]  adc_channel,
  output logic      [7:0]  sar_code,
  output logic             sample_hold,
  output logic             comp_power_on,
  // events
  output logic             conversion_done_irq
);

  adcts_state_e st_q;
  adcts_state_e st_d;
  logic [7:0]  adc_mode_reg_q;
  logic [7:0]  conversion_result_q;
  logic        conversion_irq_flag_q;
  logic        unread_q;
  logic        done_irq_q;
  logic        power_q;
  logic [2:0]  ch_q;
  logic [2:0]  ch_d;
  logic [9:0]  dly_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        comp_s1_q;
  logic        comp_s2_q;
  logic        lp_s1_q;
  logic        lp_s2_q;
  logic        sar_start;
  logic        sar_abort;
  logic        sar_busy;
  logic        sar_done;
  logic        sar_sample;
  logic [7:0]  sar_code_w;
  logic        acc;
  logic        acc_end;
  logic        mode_wr;
  logic        stat_wr;
  logic        res_rd;
  logic        run;
  logic        external_trigger_select;
  logic        scan;
  logic        variant;
  logic [2:0]  chf;
  logic        edge_ok;
  logic        discard;
  logic        accept;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == {4'h0, ADCTS_MODE_OFS}) || (a == {4'h0, ADCTS_RESULT_OFS}) ||
             (a == {4'h0, ADCTS_STATUS_OFS});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pins from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      lp_s1_q   <= 1'b0;
      lp_s2_q   <= 1'b0;
    end else begin
      comp_s1_q <= comp_in;
      comp_s2_q <= comp_s1_q;
      lp_s1_q   <= low_power_req;
      lp_s2_q   <= lp_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: one wait state, write takes effect at the pready edge
  assign acc     = psel && penable;
  assign acc_end = acc && pready_q;
  assign mode_wr = acc_end && pwrite && !pslverr_q && (paddr[7:0] == ADCTS_MODE_OFS);
  assign stat_wr = acc_end && pwrite && !pslverr_q && (paddr[7:0] == ADCTS_STATUS_OFS);
  assign res_rd  = acc_end && !pwrite && !pslverr_q && (paddr[7:0] == ADCTS_RESULT_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !mapped(paddr);
      if (acc && !pready_q && !pwrite) begin
        case (paddr[7:0])
          ADCTS_MODE_OFS:   prdata_q <= {24'h000000, adc_mode_reg_q};
          ADCTS_RESULT_OFS: prdata_q <= {24'h000000, conversion_result_q};
          ADCTS_STATUS_OFS: prdata_q <= {25'h0000000, ch_q, unread_q,
                                         (st_q == ST_WAIT || st_q == ST_DLY),
                                         (st_q == ST_CONV), conversion_irq_flag_q};
          default:          prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_mode_reg_q <= ADCTS_MODE_RST;
    end else if (mode_wr) begin
      adc_mode_reg_q <= pwdata[7:0];
    end
  end

  assign run     = adc_mode_reg_q[ADCTS_RUN_BIT];
  assign external_trigger_select     = adc_mode_reg_q[ADCTS_TRG_BIT];
  assign scan    = adc_mode_reg_q[ADCTS_SCAN_BIT];
  assign variant = adc_mode_reg_q[ADCTS_SCAN_VARIANT_BIT];
  assign chf     = adc_mode_reg_q[ADCTS_CH_MSB:ADCTS_CH_LSB];

  // edge already qualified by the edge detector; ignored in software start
  assign edge_ok = trigger_edge_input && external_trigger_select;
  // unread result in scan variant 1: the conversion is thrown away
  assign discard = scan && variant && unread_q;
  assign accept  = (st_q == ST_CONV) && sar_done && !discard;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; any mode write passes through idle to pick up the new settings
  always_comb begin
    st_d      = st_q;
    ch_d      = ch_q;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    if (lp_s2_q || mode_wr || !run) begin
      st_d      = ST_IDLE;
      sar_abort = 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (external_trigger_select) begin
            st_d = ST_WAIT;
          end else begin
            st_d      = ST_CONV;
            sar_start = 1'b1;
            ch_d      = scan ? 3'h0 : chf;
          end
        end
        ST_WAIT: begin
          if (edge_ok) begin
            st_d = ST_DLY;
          end
        end
        ST_DLY: begin
          if (!edge_ok && dly_q == ADCTS_TRIG_DLY_CYC - 10'h001) begin
            st_d      = ST_CONV;
            sar_start = 1'b1;
            ch_d      = scan ? 3'h0 : chf;
          end
        end
        ST_CONV: begin
          if (edge_ok) begin
            st_d      = ST_DLY;
            sar_abort = 1'b1;
          end else if (sar_done) begin
            sar_start = 1'b1;
            if (!discard) begin
              ch_d = !scan ? chf : (ch_q == chf) ? 3'h0 : 3'(ch_q + 3'h1);
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      ch_q <= 3'h0;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
    end
  end

  // a new edge during the delay restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q <= 10'h000;
    end else if (st_q != ST_DLY || edge_ok) begin
      dly_q <= 10'h000;
    end else begin
      dly_q <= dly_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result, done pulse and flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_q <= 8'h00;
      done_irq_q          <= 1'b0;
    end else begin
      done_irq_q <= accept;
      if (accept) begin
        conversion_result_q <= sar_code_w;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_irq_flag_q <= 1'b0;
    end else if (accept) begin
      conversion_irq_flag_q <= 1'b1;
    end else if (stat_wr && pwdata[ADCTS_ST_FLAG_BIT]) begin
      conversion_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unread_q <= 1'b0;
    end else if (accept) begin
      unread_q <= 1'b1;
    end else if (res_rd || mode_wr) begin
      unread_q <= 1'b0;
    end
  end

  // comparator power follows run, not the low-power request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_q <= 1'b0;
    end else begin
      power_q <= run;
    end
  end

  adcts_sar u_sar (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (sar_start),
    .abort    (sar_abort),
    .fast     (adc_mode_reg_q[ADCTS_SPEED_BIT]),
    .comp_hi  (comp_s2_q),
    .busy_q   (sar_busy),
    .done_q   (sar_done),
    .sample_q (sar_sample),
    .code_q   (sar_code_w)
  );

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign adc_channel         = ch_q;
  assign sar_code            = sar_code_w;
  assign sample_hold         = sar_sample;
  assign comp_power_on       = power_q;
  assign conversion_done_irq = done_irq_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_scan_first_ch: assert property (
    (st_q != ST_CONV && st_d == ST_CONV && scan) |=> adc_channel == 3'h0)
    else $error("scan did not start at channel 0");
  a_scan_next_ch: assert property (
    (accept && sar_start && scan && ch_q != chf) |=> adc_channel == $past(ch_q) + 3'h1)
    else $error("scan did not advance");
  a_done_pulse: assert property (
    accept |=> conversion_done_irq ##1 !conversion_done_irq || accept)
    else $error("done interrupt missing");
  a_arm_needs_bits: assert property (
    st_q == ST_WAIT |-> run && external_trigger_select)
    else $error("armed without trigger select and run");
  a_wait_no_conv: assert property (
    (st_q == ST_WAIT) |-> !sar_busy)
    else $error("converting while waiting for edge");
  a_edge_restart: assert property (
    (st_q == ST_CONV && edge_ok && !mode_wr && !lp_s2_q && run) |=>
      st_q == ST_DLY && !sar_busy)
    else $error("edge did not restart conversion");
  a_mode_rearm: assert property (
    (mode_wr && pwdata[ADCTS_RUN_BIT] && pwdata[ADCTS_TRG_BIT] && !lp_s2_q) |=>
      st_q == ST_IDLE ##1 (st_q == ST_WAIT || lp_s2_q))
    else $error("mode write did not re-arm");
  a_chain_on: assert property (
    (st_q == ST_CONV && sar_done && !edge_ok && !mode_wr && !lp_s2_q && run) |=> sar_busy)
    else $error("chaining stopped");
  a_trig_delay: assert property (
    (st_q == ST_CONV && $past(st_q) == ST_DLY) |-> $past(dly_q) == 10'h1F3)
    else $error("trigger latency wrong");
  a_select_same: assert property (
    (accept && !scan && !mode_wr) |=> adc_channel == $past(chf))
    else $error("select mode changed channel");
  a_low_power: assert property (
    lp_s2_q |=> st_q == ST_IDLE && !sar_busy && comp_power_on == $past(run))
    else $error("low power did not halt");
  a_run_clear: assert property (
    !run |=> st_q == ST_IDLE)
    else $error("running with run bit clear");

endmodule

// [src/adcts_pkg.sv]
// package: register map, field positions, timing and states of the converter sequencer
package adcts_pkg;

  // register byte offsets
  localparam logic [7:0] ADCTS_MODE_OFS   = 8'h00;
  localparam logic [7:0] ADCTS_RESULT_OFS = 8'h04;
  localparam logic [7:0] ADCTS_STATUS_OFS = 8'h08;

  // adc_mode_reg fields
  localparam int ADCTS_RUN_BIT   = 7;
  localparam int ADCTS_TRG_BIT   = 6;
  localparam int ADCTS_SCAN_VARIANT_BIT  = 5;
  localparam int ADCTS_SPEED_BIT = 4;
  localparam int ADCTS_CH_MSB    = 3;
  localparam int ADCTS_CH_LSB    = 1;
  localparam int ADCTS_SCAN_BIT  = 0;
  localparam logic [7:0] ADCTS_MODE_RST = 8'h00;

  // status register fields
  localparam int ADCTS_ST_FLAG_BIT   = 0;
  localparam int ADCTS_ST_BUSY_BIT   = 1;
  localparam int ADCTS_ST_WAIT_BIT   = 2;
  localparam int ADCTS_ST_UNREAD_BIT = 3;
  localparam int ADCTS_ST_CH_LSB     = 4;

  // conversion timing in system clocks, sampling included
  localparam logic [7:0] ADCTS_CONV_SLOW = 8'hB4;
  localparam logic [7:0] ADCTS_CONV_FAST = 8'h78;
  localparam logic [7:0] ADCTS_SAMP_SLOW = 8'h24;
  localparam logic [7:0] ADCTS_SAMP_FAST = 8'h18;
  localparam logic [7:0] ADCTS_BIT_SLOW  = 8'((ADCTS_CONV_SLOW - ADCTS_SAMP_SLOW) / 8);
  localparam logic [7:0] ADCTS_BIT_FAST  = 8'((ADCTS_CONV_FAST - ADCTS_SAMP_FAST) / 8);

  // trigger-to-start latency
  localparam int ADCTS_CLK_MHZ     = 50;
  localparam int ADCTS_TRIG_DLY_US = 10;
  localparam logic [9:0] ADCTS_TRIG_DLY_CYC = 10'(ADCTS_TRIG_DLY_US * ADCTS_CLK_MHZ);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DLY  = 2'b11,
    ST_CONV = 2'b10
  } adcts_state_e;

endpackage

// [src/adcts_sar.sv]
// successive approximation timing engine for one 8-bit conversion
`timescale 1ns/1ps
module adcts_sar
  import adcts_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       fast,
  input  wire logic       comp_hi,
  // status and result
  output logic            busy_q,
  output logic            done_q,
  output logic            sample_q,
  output logic [7:0]      code_q
);

  logic [7:0] cnt_q;
  logic [7:0] sub_q;
  logic [2:0] idx_q;
  logic [7:0] total;
  logic [7:0] samp;
  logic [7:0] bitc;

  assign total = fast ? ADCTS_CONV_FAST : ADCTS_CONV_SLOW;
  assign samp  = fast ? ADCTS_SAMP_FAST : ADCTS_SAMP_SLOW;
  assign bitc  = fast ? ADCTS_BIT_FAST : ADCTS_BIT_SLOW;

  ////////////////////////////////////////////////////////////////////////////
  // start restarts from scratch, so an abort-and-restart needs one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q   <= 1'b0;
      sample_q <= 1'b0;
      cnt_q    <= 8'h00;
      sub_q    <= 8'h00;
      idx_q    <= 3'h7;
      code_q   <= 8'h00;
    end else if (start) begin
      busy_q   <= 1'b1;
      sample_q <= 1'b1;
      cnt_q    <= 8'h00;
      sub_q    <= 8'h00;
      idx_q    <= 3'h7;
      code_q   <= 8'h00;
    end else if (abort) begin
      busy_q   <= 1'b0;
      sample_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (sample_q) begin
        if (cnt_q == samp - 8'h01) begin
          sample_q  <= 1'b0;
          code_q[7] <= 1'b1;
        end
      end else if (sub_q == bitc - 8'h01) begin
        sub_q         <= 8'h00;
        code_q[idx_q] <= comp_hi;
        if (idx_q != 3'h0) begin
          code_q[3'(idx_q - 3'h1)] <= 1'b1;
          idx_q                    <= 3'(idx_q - 3'h1);
        end
      end else begin
        sub_q <= sub_q + 8'h01;
      end
      if (cnt_q == total - 8'h01) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && !start && !abort && (cnt_q == total - 8'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_q) |-> (busy_q && !done_q)[*8])
    else $error("conversion ended too early");
  a_done_count: assert property (@(posedge pclk) disable iff (!presetn)
    done_q |-> $past(cnt_q) == (fast ? 8'h77 : 8'hB3))
    else $error("conversion length wrong");

endmodule

// [tb/adcts_afe_model.sv]
// analog front end model: per-channel input level and comparator
`timescale 1ns/1ps
module adcts_afe_model
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // converter side
  input  wire logic [2:0] adc_channel,
  input  wire logic [7:0] sar_code,
  input  wire logic       comp_power_on,
  // comparator
  output logic            comp_in
);
  logic [7:0] level;
  // each channel has its own level so a result names its channel
  assign level = {adc_channel, 5'h16};
  // an unpowered comparator toggles, so a stale answer is never mistaken for a good one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_in <= 1'b0;
    end else if (comp_power_on) begin
      comp_in <= (level >= sar_code);
    end else begin
      comp_in <= ~comp_in;
    end
  end
endmodule

// [tb/test_adc_trigger_sequencer.sv]
// self-checking bench for the converter trigger sequencer
`timescale 1ns/1ps
module test_adc_trigger_sequencer
  import adcts_pkg::*;
;
  localparam logic [31:0] M_RUN  = 32'h0000_0080;
  localparam logic [31:0] M_TRG  = 32'h0000_0040;
  localparam logic [31:0] M_SCAN_VARIANT = 32'h0000_0020;
  localparam logic [31:0] M_FAST = 32'h0000_0010;
  localparam logic [31:0] M_SCAN = 32'h0000_0001;
  localparam logic [11:0] A_MODE = 12'(ADCTS_MODE_OFS);
  localparam logic [11:0] A_RES  = 12'(ADCTS_RESULT_OFS);
  localparam logic [11:0] A_ST   = 12'(ADCTS_STATUS_OFS);
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        trigger_edge_input, low_power_req, comp_in, sample_hold;
  logic        comp_power_on, conversion_done_irq;
  logic [2:0]  adc_channel;
  logic [7:0]  sar_code;
  int          bad_count, comparisons;

  adcts_trigger_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_edge_input(trigger_edge_input), .low_power_req(low_power_req),
    .comp_in(comp_in), .adc_channel(adc_channel), .sar_code(sar_code),
    .sample_hold(sample_hold), .comp_power_on(comp_power_on),
    .conversion_done_irq(conversion_done_irq));
  adcts_afe_model afe_u (.pclk(pclk), .presetn(presetn), .adc_channel(adc_channel),
    .sar_code(sar_code), .comp_power_on(comp_power_on), .comp_in(comp_in));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    bad_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi, input string m);
    comparisons++;
    if (g < lo || g > hi) fail($sformatf("%s got %0d", m, g));
  endtask
  // request held until pready is seen at an edge; data taken at that edge only
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail("apb hang");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic chk_res(input logic [2:0] ch);
    logic [31:0] r;
    rd(A_RES, r);
    chk_val(r, {24'h0, ch, 5'h16}, "result");
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conversion_done_irq !== 1'b1 && n < 2000);
    if (n >= 2000) fail("no done");
  endtask
  // a few settling cycles first, so the tail of an aborted conversion is not counted
  task automatic quiet(input int c, input logic sh, output int h);
    h = 0;
    repeat (4) @(posedge pclk);
    repeat (c) begin
      @(posedge pclk);
      if (conversion_done_irq !== 1'b0 || (sh && sample_hold !== 1'b0)) h++;
    end
  endtask
  task automatic pulse;
    @(posedge pclk);
    trigger_edge_input <= 1'b1;
    @(posedge pclk);
    trigger_edge_input <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(A_MODE, r);
    chk_val(r, 32'h0, "mode reset");
    rd(A_ST, r);
    chk_val(r, 32'h0, "status reset");
    apb(1'b1, 12'h00C, 32'h0000_00FF, r, e);
    chk_val(e, 1'b1, "unmapped err");
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk_val(r, 32'h0, "unmapped data");
    rd(A_MODE, r);
    chk_val(r, 32'h0, "mode kept");
    $display("test reset done");
  endtask
  // chained conversions are one hand-over cycle apart; the pulse task eats two edges
  task automatic t_select;
    int          n, p;
    logic [31:0] r;
    for (int s = 0; s < 2; s++) begin
      p = s ? int'(ADCTS_CONV_FAST) : int'(ADCTS_CONV_SLOW);
      wr(A_MODE, M_RUN | (s ? M_FAST : 32'h0) | 32'h0000_000A);
      wait_done(n);
      pulse();
      wait_done(n);
      chk_rng(n, p - 1, p - 1, "select period");
      chk_res(3'd5);
      rd(A_ST, r);
      chk_val(r[6:0], 7'h53, "status");
      wr(A_ST, 32'h1);
      rd(A_ST, r);
      chk_val(r[0], 1'b0, "flag clear");
    end
    $display("test select done");
  endtask
  task automatic t_scan;
    int n, h;
    wr(A_MODE, M_RUN | M_FAST | M_SCAN | 32'h0000_0004);
    for (int i = 0; i < 5; i++) begin
      wait_done(n);
      chk_res(3'(i % 3));
    end
    wr(A_MODE, M_RUN | M_FAST | M_SCAN | M_SCAN_VARIANT | 32'h0000_0002);
    wait_done(n);
    quiet(200, 1'b0, h);
    chk_rng(h, 0, 0, "unread discard");
    chk_res(3'd0);
    wait_done(n);
    chk_res(3'd1);
    $display("test scan done");
  endtask
  task automatic t_hw;
    int          n, h;
    logic [31:0] r;
    wr(A_MODE, M_RUN | M_TRG | M_FAST | M_SCAN | 32'h0000_0002);
    quiet(300, 1'b1, h);
    chk_rng(h, 0, 0, "armed idle");
    rd(A_ST, r);
    chk_val(r[2], 1'b1, "waiting");
    pulse();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sample_hold !== 1'b1 && n < 1000);
    chk_rng(n, 498, 506, "trigger latency");
    wait_done(n);
    chk_res(3'd0);
    wait_done(n);
    chk_res(3'd1);
    wait_done(n);
    repeat (60) @(posedge pclk);
    pulse();
    quiet(480, 1'b0, h);
    chk_rng(h, 0, 0, "edge abort");
    wait_done(n);
    chk_res(3'd0);
    wr(A_MODE, M_RUN | M_TRG | M_FAST | 32'h0000_0006);
    quiet(600, 1'b0, h);
    chk_rng(h, 0, 0, "rearm wait");
    rd(A_ST, r);
    chk_val(r[2], 1'b1, "rearmed");
    pulse();
    wait_done(n);
    chk_rng(n, 500, 640, "select start");
    chk_res(3'd3);
    $display("test hardware start done");
  endtask
  // software start sequences: stop first, or restart and clear the flag at once
  task automatic t_order;
    int          n;
    logic [31:0] r;
    wr(A_MODE, 32'h0);
    wr(A_ST, 32'h1);
    rd(A_ST, r);
    chk_val(r[1:0], 2'h0, "stopped and clear");
    wr(A_MODE, M_RUN | M_SCAN | 32'h0000_0002);
    wait_done(n);
    chk_res(3'd0);
    wr(A_MODE, M_RUN | M_SCAN | 32'h0000_0002);
    wr(A_ST, 32'h1);
    rd(A_ST, r);
    chk_val(r[1:0], 2'h2, "no stale flag");
    wait_done(n);
    chk_res(3'd0);
    $display("test software order done");
  endtask
  task automatic t_stop;
    int n, h;
    wr(A_MODE, M_RUN | M_FAST | 32'h0000_0004);
    wait_done(n);
    @(posedge pclk);
    low_power_req <= 1'b1;
    quiet(300, 1'b0, h);
    chk_rng(h, 0, 0, "low power halt");
    chk_val(comp_power_on, 1'b1, "comparator on");
    @(posedge pclk);
    low_power_req <= 1'b0;
    wait_done(n);
    chk_res(3'd2);
    wr(A_MODE, 32'h0);
    quiet(300, 1'b0, h);
    chk_rng(h, 0, 0, "run cleared");
    chk_val(comp_power_on, 1'b0, "comparator off");
    $display("test stop done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn            = 1'b0;
    psel               = 1'b0;
    penable            = 1'b0;
    pwrite             = 1'b0;
    paddr              = 12'h000;
    pwdata             = 32'h0;
    trigger_edge_input = 1'b0;
    low_power_req      = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_select();
    t_scan();
    t_hw();
    t_order();
    t_stop();
    finish_test();
  end
  // the planned run is near 6000 cycles; this leaves ample margin
  initial begin
    repeat (30000) @(posedge pclk);
    fail("timeout");
    finish_test();
  end
endmodule
